// ===== hw/abu_answerback_unit.sv
// abu_answerback_unit: answerback message store, trigger decode and serial sender.
// assumes all inputs synchronous to hclk; one ahb-lite master; the terminal
// control grants each character with send_enable_n.
`timescale 1ns/1ps

module abu_answerback_unit (
    input wire logic hclk, // system clock, 100 mhz
    input wire logic hresetn, // async reset, active low
    input wire logic hsel, // slave select
    input wire logic [7:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // word only
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready in
    output logic [31:0] hrdata, // read data
    output logic hreadyout, // always ready
    output logic hresp, // always okay
    input wire logic on_line, // terminal on line
    input wire logic keyboard_off, // keyboard switched off
    input wire logic half_duplex, // half duplex mode
    input wire logic printer_on_line, // printer on line
    input wire logic recorder_on_line, // recorder on line
    input wire logic identify_key, // local identify key, level
    input wire logic remote_trigger_n, // remote trigger, low pulse
    input wire logic remote_clear_n, // remote clear, low holds
    input wire logic [7:0] rx_char, // received character
    input wire logic rx_valid, // one-cycle strobe with rx_char
    input wire logic send_enable_n, // grant from control, low
    output logic char_request_n, // character request, low
    output logic serial_data, // character bit onto data bus
    output logic serial_valid, // high while a bit is on the bus
    output logic printer_holdoff_n, // printer hold-off, low
    output logic recorder_holdoff_n, // recorder hold-off, low
    output logic sender_busy_n, // busy, low
    output logic message_end_stop, // end reached, level until retrigger or remote clear
    output logic active_indication // message active indication
);

    // ----------------------------------------------------------------
    // storage and state
    // ----------------------------------------------------------------
    logic [7:0] msg_q [abu_pkg::NUM_CHARS];
    logic [abu_pkg::CFG_WIDTH-1:0] cfg_q;
    logic [abu_pkg::TEST_WIDTH-1:0] test_q;
    abu_pkg::abu_state_t state_q;
    logic [4:0] count_q;
    logic [2:0] bit_q;
    logic [7:0] shreg_q;
    logic line_trigger_latch_q;
    logic key_trigger_latch_q;
    logic key_prev_q;
    logic remote_prev_q;
    logic figs_seen_q;
    logic stop_q;
    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    logic hreadyout_q;
    logic [31:0] hrdata_q;
    logic char_request_n_q;
    logic serial_data_q;
    logic serial_valid_q;
    logic printer_holdoff_n_q;
    logic recorder_holdoff_n_q;
    logic sender_busy_n_q;
    logic active_indication_q;

    // clear follows remote_clear_n directly and holds while it is low, so the clear source is a plain synchronous term
    logic clear;
    logic busy;
    logic mode_ascii;
    logic mode_baudot;
    logic line_ignored;
    logic key_fire;
    logic line_fire;
    logic start;
    logic last_char;
    logic addr_ok;

    // effective character bits after the test switches
    function automatic logic [6:0] row_bits(input logic [4:0] row);
        logic [6:0] b;
        b = msg_q[row][6:0];
        if (row == 5'd14 && !test_q[0]) b[6] = 1'b0;
        if (row == 5'd20 && !test_q[1]) b[0] = 1'b0;
        if (row == 5'd15 && !test_q[2]) b[5] = 1'b0;
        if (row == 5'd16 && !test_q[3]) b[4] = 1'b0;
        if (row == 5'd17 && !test_q[4]) b[3] = 1'b0;
        if (row == 5'd18 && !test_q[5]) b[2] = 1'b0;
        if (row == 5'd19 && !test_q[6]) b[1] = 1'b0;
        return b;
    endfunction

    // ----------------------------------------------------------------
    // mode and trigger decode
    // ----------------------------------------------------------------
    assign clear = !remote_clear_n;
    assign busy = (state_q != abu_pkg::ST_IDLE_E);
    assign mode_ascii = (cfg_q[2:0] == abu_pkg::CFG_ASCII_LOW)
        && (cfg_q[4:3] == abu_pkg::CFG_ASCII_HIGH);
    assign mode_baudot = (cfg_q[2:0] == ~abu_pkg::CFG_ASCII_LOW)
        && (cfg_q[4:3] == ~abu_pkg::CFG_ASCII_HIGH);
    assign line_ignored = !cfg_q[abu_pkg::CFG_SEL1] && !cfg_q[abu_pkg::CFG_SEL4];
    // key edge, or the falling edge of the remote pulse, both need on line
    assign key_fire = on_line && ((identify_key && !key_prev_q && !keyboard_off)
        || (!remote_trigger_n && remote_prev_q));
    assign line_fire = rx_valid && !line_ignored
        && ((mode_ascii && rx_char == abu_pkg::ASCII_ENQ)
        || (mode_baudot && figs_seen_q && rx_char == abu_pkg::BAUDOT_D));
    assign start = (state_q == abu_pkg::ST_IDLE_E)
        && (line_trigger_latch_q || key_trigger_latch_q);
    // last character, ignore stop open: 21 sent, or first flagged row from the third on
    assign last_char = !cfg_q[abu_pkg::CFG_IGNORE_STOP]
        && ((count_q == 5'(abu_pkg::NUM_CHARS - 1))
        || (count_q >= 5'(abu_pkg::FIRST_FLAG_ROW)
        && msg_q[count_q][abu_pkg::ROW_FLAG_BIT]));

    // edge history and the baudot figs-shift memory
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            key_prev_q <= 1'b0;
            remote_prev_q <= 1'b1;
            figs_seen_q <= 1'b0;
        end else begin
            key_prev_q <= identify_key;
            remote_prev_q <= remote_trigger_n;
            if (clear) begin
                figs_seen_q <= 1'b0;
            end else if (rx_valid) begin
                figs_seen_q <= (rx_char == abu_pkg::BAUDOT_FIGS);
            end
        end
    end

    // trigger latches: a new trigger wins over the clear at start
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            line_trigger_latch_q <= 1'b0;
            key_trigger_latch_q <= 1'b0;
        end else if (clear) begin
            line_trigger_latch_q <= 1'b0;
            key_trigger_latch_q <= 1'b0;
        end else begin
            if (line_fire) begin
                line_trigger_latch_q <= 1'b1;
            end else if (start) begin
                line_trigger_latch_q <= 1'b0;
            end
            if (key_fire) begin
                key_trigger_latch_q <= 1'b1;
            end else if (start || !on_line) begin
                key_trigger_latch_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // transmit sequencer
    // ----------------------------------------------------------------
    // counter sits at zero while idle; busy releases it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= abu_pkg::ST_IDLE_E;
            count_q <= 5'h00;
            bit_q <= 3'h0;
            shreg_q <= 8'h00;
            stop_q <= 1'b0;
        end else if (clear) begin
            state_q <= abu_pkg::ST_IDLE_E;
            count_q <= 5'h00;
            bit_q <= 3'h0;
            stop_q <= 1'b0;
        end else begin
            unique case (state_q)
                abu_pkg::ST_IDLE_E: begin
                    count_q <= 5'h00;
                    if (start) begin
                        state_q <= abu_pkg::ST_REQ_E;
                        stop_q <= 1'b0;
                    end
                end
                abu_pkg::ST_REQ_E: begin
                    shreg_q <= {1'b0, row_bits(count_q)};
                    bit_q <= 3'h0;
                    if (!send_enable_n) begin
                        state_q <= abu_pkg::ST_SHIFT_E;
                    end
                end
                abu_pkg::ST_SHIFT_E: begin
                    shreg_q <= {1'b0, shreg_q[7:1]};
                    bit_q <= bit_q + 3'h1;
                    if (bit_q == 3'(abu_pkg::SHIFT_CLOCKS - 1)) begin
                        state_q <= abu_pkg::ST_NEXT_E;
                    end
                end
                abu_pkg::ST_NEXT_E: begin
                    if (last_char) begin
                        state_q <= abu_pkg::ST_IDLE_E;
                        stop_q <= 1'b1;
                    end else begin
                        state_q <= abu_pkg::ST_REQ_E;
                        count_q <= (count_q == 5'(abu_pkg::NUM_CHARS - 1))
                            ? 5'h00 : count_q + 5'h01;
                    end
                end
            endcase
        end
    end

    // request and serial bit outputs, all from flops
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            char_request_n_q <= 1'b1;
            serial_data_q <= 1'b0;
            serial_valid_q <= 1'b0;
        end else begin
            char_request_n_q <= !(state_q == abu_pkg::ST_REQ_E && !clear);
            serial_valid_q <= (state_q == abu_pkg::ST_SHIFT_E) && !clear;
            serial_data_q <= (state_q == abu_pkg::ST_SHIFT_E) && !clear && shreg_q[0];
        end
    end

    // busy, hold-offs and indication follow the sequencer one cycle late
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sender_busy_n_q <= 1'b1;
            printer_holdoff_n_q <= 1'b1;
            recorder_holdoff_n_q <= 1'b1;
            active_indication_q <= 1'b0;
        end else begin
            sender_busy_n_q <= !busy;
            printer_holdoff_n_q <= !(busy && half_duplex && printer_on_line
                && cfg_q[abu_pkg::CFG_PRINT_SUPPRESS]);
            recorder_holdoff_n_q <= !(busy && half_duplex && recorder_on_line
                && cfg_q[abu_pkg::CFG_RECORD_SUPPRESS]);
            active_indication_q <= busy && cfg_q[abu_pkg::CFG_INDICATE];
        end
    end

    // ----------------------------------------------------------------
    // ahb-lite slave
    // ----------------------------------------------------------------
    // zero wait states; a read straight after a write sees the old value
    assign addr_ok = hsel && hready && (htrans == abu_pkg::HTRANS_NONSEQ
        || htrans == abu_pkg::HTRANS_SEQ);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            hreadyout_q <= 1'b1;
        end else begin
            wr_pend_q <= addr_ok && hwrite;
            hreadyout_q <= 1'b1;
            if (addr_ok) begin
                wr_addr_q <= haddr;
            end
        end
    end

    // register writes in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < abu_pkg::NUM_CHARS; i++) begin
                msg_q[i] <= 8'h00;
            end
            cfg_q <= abu_pkg::CFG_RESET;
            test_q <= abu_pkg::TEST_RESET;
        end else if (wr_pend_q) begin
            if (wr_addr_q <= abu_pkg::MSG_ROW_LAST && wr_addr_q[1:0] == 2'h0) begin
                msg_q[wr_addr_q[6:2]] <= hwdata[7:0];
            end else if (wr_addr_q == abu_pkg::CONFIG_SWITCH_OFS) begin
                cfg_q <= hwdata[abu_pkg::CFG_WIDTH-1:0];
            end else if (wr_addr_q == abu_pkg::TEST_SWITCH_OFS) begin
                test_q <= hwdata[abu_pkg::TEST_WIDTH-1:0];
            end
        end
    end

    // read data is captured in the address phase; unmapped reads are zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h0000_0000;
        end else if (addr_ok && !hwrite) begin
            hrdata_q <= 32'h0000_0000;
            if (haddr <= abu_pkg::MSG_ROW_LAST && haddr[1:0] == 2'h0) begin
                hrdata_q[7:0] <= {msg_q[haddr[6:2]][7], row_bits(haddr[6:2])};
            end else if (haddr == abu_pkg::CONFIG_SWITCH_OFS) begin
                hrdata_q[abu_pkg::CFG_WIDTH-1:0] <= cfg_q;
            end else if (haddr == abu_pkg::TEST_SWITCH_OFS) begin
                hrdata_q[abu_pkg::TEST_WIDTH-1:0] <= test_q;
            end else if (haddr == abu_pkg::STATUS_OFS) begin
                hrdata_q[abu_pkg::ST_BUSY] <= busy;
                hrdata_q[abu_pkg::ST_STOP] <= stop_q;
                hrdata_q[abu_pkg::ST_LINE_LATCH] <= line_trigger_latch_q;
                hrdata_q[abu_pkg::ST_KEY_LATCH] <= key_trigger_latch_q;
                hrdata_q[abu_pkg::ST_ASCII] <= mode_ascii;
                hrdata_q[abu_pkg::ST_BAUDOT] <= mode_baudot;
                hrdata_q[abu_pkg::ST_COUNT_LSB +: 5] <= count_q;
            end
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign hrdata = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp = 1'b0;
    assign char_request_n = char_request_n_q;
    assign serial_data = serial_data_q;
    assign serial_valid = serial_valid_q;
    assign printer_holdoff_n = printer_holdoff_n_q;
    assign recorder_holdoff_n = recorder_holdoff_n_q;
    assign sender_busy_n = sender_busy_n_q;
    assign message_end_stop = stop_q;
    assign active_indication = active_indication_q;

endmodule

// ===== hw/abu_pkg.sv
// abu_pkg: shared constants for the answerback message sender.
// assumes a 32-bit ahb-lite slave, one aligned word per register.
package abu_pkg;

    // ----------------------------------------------------------------
    // message geometry
    // ----------------------------------------------------------------
    localparam int NUM_CHARS = 21;
    localparam int CHAR_BITS = 7;
    localparam int SHIFT_CLOCKS = 8;
    localparam int FIRST_FLAG_ROW = 2; // third character, zero based
    localparam int ROW_FLAG_BIT = 7;

    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] MSG_ROW_BASE = 8'h00; // rows 0..20 at base + 4*row
    localparam logic [7:0] MSG_ROW_LAST = 8'h50;
    localparam logic [7:0] CONFIG_SWITCH_OFS = 8'h60;
    localparam logic [7:0] TEST_SWITCH_OFS = 8'h64;
    localparam logic [7:0] STATUS_OFS = 8'h68;

    // ----------------------------------------------------------------
    // config switch bank fields (1 = closed)
    // ----------------------------------------------------------------
    localparam int CFG_WIDTH = 9;
    localparam int CFG_SEL1 = 0;
    localparam int CFG_SEL4 = 3;
    localparam int CFG_PRINT_SUPPRESS = 5;
    localparam int CFG_RECORD_SUPPRESS = 6;
    localparam int CFG_INDICATE = 7;
    localparam int CFG_IGNORE_STOP = 8;
    localparam logic [2:0] CFG_ASCII_LOW = 3'h7;
    localparam logic [1:0] CFG_ASCII_HIGH = 2'h0;
    localparam logic [8:0] CFG_RESET = 9'h007; // ascii; suppress, indicate and ignore stop open
    localparam int TEST_WIDTH = 7;
    localparam logic [6:0] TEST_RESET = 7'h7F; // all test switches closed

    // ----------------------------------------------------------------
    // status register fields
    // ----------------------------------------------------------------
    localparam int ST_BUSY = 0;
    localparam int ST_STOP = 1;
    localparam int ST_LINE_LATCH = 2;
    localparam int ST_KEY_LATCH = 3;
    localparam int ST_ASCII = 4;
    localparam int ST_BAUDOT = 5;
    localparam int ST_COUNT_LSB = 8;

    // ----------------------------------------------------------------
    // received trigger codes
    // ----------------------------------------------------------------
    localparam logic [7:0] ASCII_ENQ = 8'h05;
    localparam logic [7:0] BAUDOT_FIGS = 8'h1B;
    localparam logic [7:0] BAUDOT_D = 8'h09;

    // ----------------------------------------------------------------
    // ahb-lite encodings
    // ----------------------------------------------------------------
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;

    typedef enum logic [3:0] {
        ST_IDLE_E = 4'h1,
        ST_REQ_E = 4'h2,
        ST_SHIFT_E = 4'h4,
        ST_NEXT_E = 4'h8
    } abu_state_t;

endpackage

// ===== tb/abu_answerback_unit_props.sv
// abu_answerback_unit_props: port-level checks of the answerback sender.
// assumes it is bound onto abu_answerback_unit; one hclk domain.
`timescale 1ns/1ps

module abu_answerback_unit_props (
    input wire logic hclk, // system clock
    input wire logic hresetn, // reset, low
    input wire logic remote_clear_n, // remote clear, low
    input wire logic half_duplex, // duplex mode
    input wire logic printer_on_line, // printer on line
    input wire logic recorder_on_line, // recorder on line
    input wire logic send_enable_n, // grant, low
    input wire logic char_request_n, // request, low
    input wire logic serial_data, // character bit
    input wire logic serial_valid, // bit valid
    input wire logic printer_holdoff_n, // printer hold-off
    input wire logic recorder_holdoff_n, // recorder hold-off
    input wire logic sender_busy_n, // busy, low
    input wire logic message_end_stop // end reached
);
    // ----------------------------------------------------------------
    // handshake, framing, hold-off, stop and clear checks
    // ----------------------------------------------------------------
    // a remote clear may cut a character short, so the handshake and shift-window checks step aside then; the pad check does not
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_req_busy: assert property (!char_request_n |-> !sender_busy_n)
        else $error("request without busy");
    a_req_holds: assert property (disable iff (!hresetn || !remote_clear_n)
        !char_request_n && send_enable_n |=> !char_request_n)
        else $error("request dropped before grant");
    a_req_release: assert property (disable iff (!hresetn || !remote_clear_n)
        !char_request_n && !send_enable_n |-> ##[1:2] char_request_n)
        else $error("request kept after grant");
    a_shift_start: assert property (disable iff (!hresetn || !remote_clear_n)
        !char_request_n && !send_enable_n |-> ##[1:2] serial_valid)
        else $error("no shift after grant");
    a_shift_eight: assert property (disable iff (!hresetn || !remote_clear_n)
        $rose(serial_valid) |-> serial_valid [*8] ##1 !serial_valid)
        else $error("shift window not eight clocks");
    a_pad_zero: assert property ($fell(serial_valid) |-> !$past(serial_data))
        else $error("eighth bit not zero");
    a_prn_holdoff: assert property (!printer_holdoff_n |-> half_duplex && printer_on_line)
        else $error("printer held off out of half duplex");
    a_rec_holdoff: assert property (!recorder_holdoff_n |-> half_duplex && recorder_on_line)
        else $error("recorder held off out of half duplex");
    a_stop_blocks: assert property (message_end_stop |-> char_request_n)
        else $error("request while stopped");
    a_clear_holds: assert property (!remote_clear_n [*3] |-> sender_busy_n && char_request_n)
        else $error("not cleared under remote clear");
endmodule

bind abu_answerback_unit abu_answerback_unit_props u_props (.hclk, .hresetn, .remote_clear_n,
    .half_duplex, .printer_on_line, .recorder_on_line, .send_enable_n, .char_request_n,
    .serial_data, .serial_valid, .printer_holdoff_n, .recorder_holdoff_n, .sender_busy_n,
    .message_end_stop);

// ===== tb/abu_answerback_unit_tb_top.sv
// abu_answerback_unit_tb_top: self-checking bench for the answerback sender.
// assumes abu_term_ctrl on the grant side and the bound checker.
`timescale 1ns/1ps

module abu_answerback_unit_tb_top;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata;
    logic on_line, keyboard_off, half_duplex, printer_on_line, recorder_on_line;
    logic identify_key, remote_trigger_n, remote_clear_n, rx_valid, send_enable_n;
    logic [7:0] rx_char;
    logic char_request_n, serial_data, serial_valid, printer_holdoff_n, recorder_holdoff_n;
    logic sender_busy_n, message_end_stop, active_indication, arm;
    logic [2:0] seen;
    logic [3:0] slow;
    logic [7:0] rows [21];
    logic [6:0] tst;
    int cyc, n_mismatch, compares;
    int frow [7] = '{14, 20, 15, 16, 17, 18, 19};
    int fbit [7] = '{6, 0, 5, 4, 3, 2, 1};

    assign hready = hreadyout; // single slave
    abu_answerback_unit dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready, .hrdata, .hreadyout, .hresp, .on_line, .keyboard_off, .half_duplex,
        .printer_on_line, .recorder_on_line, .identify_key, .remote_trigger_n, .remote_clear_n,
        .rx_char, .rx_valid, .send_enable_n, .char_request_n, .serial_data, .serial_valid,
        .printer_holdoff_n, .recorder_holdoff_n, .sender_busy_n, .message_end_stop,
        .active_indication);
    abu_term_ctrl ctrl (.hclk, .hresetn, .char_request_n, .serial_data, .serial_valid,
        .slow, .send_enable_n);

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    // hold-off and indication seen since the last key or rx task; cycle ceiling
    always @(posedge hclk) begin
        seen <= arm ? 3'h0 : seen | {~printer_holdoff_n, ~recorder_holdoff_n, active_indication};
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("FAIL %0t got %h exp %h", $time, g, e);
        end
    endtask

    // one single-word transfer; waits on hready, no fixed latency assumed
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
        output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= abu_pkg::HTRANS_NONSEQ;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        r = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(a, 1'b1, d, r);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] r;
        bus(a, 1'b0, 32'h0, r);
        chk(r & m, e);
        chk(hresp, 1'b0);
    endtask

    task automatic prog(input int i, input logic [7:0] v);
        wr(8'(i * 4), {24'h0, v});
        rows[i] = v;
    endtask

    // expected byte on the wire: flag dropped, test switches applied, zero pad
    function automatic logic [7:0] fexp(input int i);
        logic [6:0] m;
        m = 7'h7F;
        for (int k = 0; k < 7; k++) if (i == frow[k] && !tst[k]) m[fbit[k]] = 1'b0;
        return {1'b0, rows[i][6:0] & m};
    endfunction

    task automatic key();
        arm <= 1'b1;
        identify_key <= 1'b1;
        @(posedge hclk);
        arm <= 1'b0;
        repeat (2) @(posedge hclk);
        identify_key <= 1'b0;
        @(posedge hclk);
    endtask

    task automatic rx(input logic [7:0] a, input logic [7:0] b, input logic two);
        arm <= 1'b1;
        rx_char <= a;
        rx_valid <= 1'b1;
        @(posedge hclk);
        arm <= 1'b0;
        if (two) begin
            rx_char <= b;
            @(posedge hclk);
        end
        rx_valid <= 1'b0;
        @(posedge hclk);
    endtask

    // remote low pulse of 5 us, 500 clocks
    task automatic rtrig();
        remote_trigger_n <= 1'b0;
        repeat (500) @(posedge hclk);
        remote_trigger_n <= 1'b1;
        @(posedge hclk);
    endtask

    task automatic msg(input int n);
        if (n == 0) repeat (40) @(posedge hclk);
        while (n > 0 && sender_busy_n !== 1'b0 && ctrl.rxq.size() < n) @(posedge hclk);
        while (n > 0 && message_end_stop !== 1'b1) @(posedge hclk);
        chk(ctrl.rxq.size(), n);
        for (int k = 0; k < n && k < ctrl.rxq.size(); k++) chk(ctrl.rxq[k], fexp(k));
        ctrl.rxq.delete();
    endtask

    initial begin
        {hresetn, hsel, hwrite, htrans, haddr, hwdata, rx_char, rx_valid, arm} = '0;
        {on_line, keyboard_off, half_duplex, printer_on_line, recorder_on_line} = 5'h10;
        {identify_key, remote_trigger_n, remote_clear_n, slow, tst} = {3'h3, 4'h0, 7'h7F};
        hsize = 3'h2;
        for (int i = 0; i < 21; i++) rows[i] = 8'h00;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(8'h60, 32'hFFFFFFFF, 32'h007);
        rd(8'h64, 32'hFFFFFFFF, 32'h07F);
        rd(8'h00, 32'hFFFFFFFF, 32'h000);
        wr(8'h70, 32'hFFFFFFFF);
        rd(8'h70, 32'hFFFFFFFF, 32'h000);
        for (int i = 0; i < 21; i++) prog(i, (i == 4 || i == 6) ? 8'(8'hC1 + i) : 8'(8'h41 + i));
        rd(8'h10, 32'hFFFFFFFF, 32'h0C5);
        {half_duplex, printer_on_line, recorder_on_line} <= 3'h7;
        wr(8'h60, 32'h0E7);
        key();
        msg(5);
        chk(seen, 3'h7);
        rd(8'h68, 32'h12, 32'h12);
        wr(8'h60, 32'h007);
        slow <= 4'h5;
        rx(abu_pkg::ASCII_ENQ, 8'h00, 1'b0);
        msg(5);
        chk(seen, 3'h0);
        slow <= 4'h0;
        keyboard_off <= 1'b1;
        key();
        msg(0);
        keyboard_off <= 1'b0;
        wr(8'h60, 32'h006);
        rx(abu_pkg::ASCII_ENQ, 8'h00, 1'b0);
        msg(0);
        key();
        msg(5);
        wr(8'h60, 32'h018);
        rd(8'h68, 32'h30, 32'h20);
        rx(abu_pkg::ASCII_ENQ, 8'h00, 1'b0);
        msg(0);
        rx(abu_pkg::BAUDOT_FIGS, 8'h05, 1'b1);
        rx(abu_pkg::BAUDOT_D, 8'h00, 1'b0);
        msg(0);
        rx(abu_pkg::BAUDOT_FIGS, abu_pkg::BAUDOT_D, 1'b1);
        msg(5);
        wr(8'h60, 32'h007);
        on_line <= 1'b0;
        rtrig();
        msg(0);
        on_line <= 1'b1;
        rtrig();
        msg(5);
        for (int i = 0; i < 21; i++) prog(i, 8'h7F);
        wr(8'h64, 32'h000);
        tst = 7'h00;
        rd(8'h38, 32'hFFFFFFFF, 32'h03F);
        key();
        msg(21);
        wr(8'h64, 32'h07F);
        tst = 7'h7F;
        for (int i = 0; i < 6; i++) prog(i, (i == 4) ? 8'hC5 : 8'(8'h41 + i));
        wr(8'h60, 32'h107);
        key();
        while (ctrl.rxq.size() < 23) @(posedge hclk);
        remote_clear_n <= 1'b0;
        repeat (3) @(posedge hclk);
        chk({sender_busy_n, char_request_n}, 2'h3);
        remote_clear_n <= 1'b1;
        chk(ctrl.rxq[5], fexp(5));
        chk(ctrl.rxq[21], fexp(0));
        complete_run();
    end
endmodule

// ===== tb/abu_term_ctrl.sv
// abu_term_ctrl: behavioural terminal control granting each character.
// assumes the sender's request/grant handshake and lsb-first serial bits.
`timescale 1ns/1ps

module abu_term_ctrl (
    input wire logic hclk, // system clock
    input wire logic hresetn, // reset, low
    input wire logic char_request_n, // request from sender
    input wire logic serial_data, // character bit
    input wire logic serial_valid, // bit valid
    input wire logic [3:0] slow, // grant delay in clocks
    output logic send_enable_n // grant, low
);
    logic [7:0] rxq [$]; // captured characters
    logic [7:0] sh;
    int nb;
    int wc;
    int hc;

    // ----------------------------------------------------------------
    // grant and capture
    // ----------------------------------------------------------------
    // grant held eight clocks past the request so the whole shift is covered
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            send_enable_n <= 1'b1;
            nb = 0;
            wc = 0;
            hc = 0;
        end else begin
            if (serial_valid === 1'b1) begin
                sh = {serial_data, sh[7:1]};
                nb++;
                if (nb == 8) begin
                    rxq.push_back(sh);
                    nb = 0;
                end
            end else begin
                nb = 0; // a cut character is dropped
            end
            if (!send_enable_n) begin
                if (char_request_n) hc++;
                if (hc >= 8) begin
                    send_enable_n <= 1'b1;
                    hc = 0;
                end
            end else if (!char_request_n) begin
                if (wc >= slow) begin
                    send_enable_n <= 1'b0;
                    wc = 0;
                end else begin
                    wc++;
                end
            end
        end
    end
endmodule
